/* File: bres_edge_walker.v */
// bresenham error stepper and pixel counter for one edge
`timescale 1ns/1ps
`include "bres_setup_map.vh"

module bres_edge_walker #(
   parameter TERM_W = 18,
   parameter LEN_W  = 15
) (
   input  wire              sys_clk_in,
   input  wire              arst_n_in,
   input  wire              err_load_in,
   input  wire [TERM_W-1:0] err_value_in,
   input  wire              start_in,
   input  wire [LEN_W-1:0]  length_in,
   input  wire              last_pixel_in,
   input  wire [TERM_W-1:0] inc_term_in,
   input  wire [TERM_W-1:0] dec_term_in,
   output reg  [TERM_W-1:0] err_out,
   output reg  [LEN_W-1:0]  remaining_out,
   output reg               busy_out,
   output reg               step_axial_out,
   output reg               step_diag_out,
   output reg               done_out
);

   wire [LEN_W-1:0] start_count;
   wire             err_negative;

   // without the last-pixel option the final pixel of the span is skipped
   assign start_count  = last_pixel_in ? length_in :
                         ((length_in == {LEN_W{1'b0}}) ? {LEN_W{1'b0}} : length_in - {{(LEN_W-1){1'b0}}, 1'b1});
   assign err_negative = err_out[TERM_W-1];

   always @(posedge sys_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         err_out        <= {TERM_W{1'b0}};
         remaining_out  <= {LEN_W{1'b0}};
         busy_out       <= 1'b0;
         step_axial_out <= 1'b0;
         step_diag_out  <= 1'b0;
         done_out       <= 1'b0;
      end else begin
         step_axial_out <= 1'b0;
         step_diag_out  <= 1'b0;
         done_out       <= 1'b0;
         if (busy_out) begin
            if (err_negative) begin
               err_out        <= err_out + inc_term_in;
               step_axial_out <= 1'b1;
            end else begin
               err_out       <= err_out + dec_term_in;
               step_diag_out <= 1'b1;
            end
            remaining_out <= remaining_out - {{(LEN_W-1){1'b0}}, 1'b1};
            if (remaining_out == {{(LEN_W-1){1'b0}}, 1'b1}) begin
               busy_out <= 1'b0;
               done_out <= 1'b1;
            end
         end else begin
            if (err_load_in) begin
               err_out <= err_value_in;
            end
            if (start_in) begin
               remaining_out <= start_count;
               busy_out      <= (start_count != {LEN_W{1'b0}});
               done_out      <= (start_count == {LEN_W{1'b0}});
            end
         end
      end
   end

endmodule // bres_edge_walker

/* File: bres_setup_map.vh */
// register map and field layout of the line and trapezoid setup block
`ifndef BRES_SETUP_MAP_VH
`define BRES_SETUP_MAP_VH

// memory-space dword indices
`define IDX_LINE_DECREMENT_TERM 8'h43
`define IDX_LINE_LENGTH_START   8'h48
`define IDX_LINE_ERROR_TERM     8'h49
`define IDX_LINE_INCREMENT_TERM 8'h4A

// term width and length word layout
`define TERM_W                  18
`define LEN_W                   15
`define WIDTH_W                 16
`define HEIGHT_W                15
`define BIT_LINE_START_INHIBIT  31
`define BIT_TRAP_START          15
`define TRAIL_LSB               16
`define TRAIL_W                 13
`define RSVD_LSB                29

// reset values
`define RST_TERM                18'h00000
`define RST_WIDTH               16'h0000
`define RST_HEIGHT              15'h0000
`define RST_DATA                32'h00000000

`endif

/* File: bresenham_line_trap_setup.v */
// setup registers and start decode for the line and trapezoid leading-edge walker
`timescale 1ns/1ps
`include "bres_setup_map.vh"

// Functional notes
// - decrement term 18-bit signed, added when not negative
// - increment term 18-bit signed, added when negative
// - negative error: axial step, add increment
// - otherwise diagonal step, add decrement
// - length write starts line; last-pixel counts all
// - length write also overwrites destination width
// - bit 31 inhibits line start only, never stored
// - length word aliases width and height fields
// - bit 15 set starts trapezoid instead
// - bits 31,15 select line/trap/load-only
// - trapezoid leading edge uses line walker
// - respond to memory space only
module bresenham_line_trap_setup #(
   parameter TERM_W   = `TERM_W,
   parameter LEN_W    = `LEN_W,
   parameter WIDTH_W  = `WIDTH_W,
   parameter HEIGHT_W = `HEIGHT_W
) (
   input  wire                sys_clk_in,
   input  wire                arst_n_in,
   input  wire                mem_space_in,
   input  wire                reg_wr_in,
   input  wire                reg_rd_in,
   input  wire [7:0]          reg_idx_in,
   input  wire [31:0]         reg_wdata_in,
   input  wire                draw_last_pixel_in,
   output reg  [31:0]         reg_rdata_out,
   output reg                 reg_rvalid_out,
   output reg  [WIDTH_W-1:0]  destination_width_out,
   output reg  [HEIGHT_W-1:0] destination_height_out,
   output reg                 line_start_out,
   output reg                 trap_start_out,
   output reg                 trap_mode_out,
   output wire                busy_out,
   output wire [TERM_W-1:0]   line_error_term_out,
   output wire [LEN_W-1:0]    remaining_out,
   output wire                step_axial_out,
   output wire                step_diag_out,
   output wire                done_out
);

   // start requests decoded from bits 31 and 15, as {line, trapezoid}
   localparam [1:0] START_NONE = 2'b00;
   localparam [1:0] START_LINE = 2'b10;
   localparam [1:0] START_TRAP = 2'b01;

   reg  [TERM_W-1:0]   line_decrement_term_r;
   reg  [TERM_W-1:0]   line_increment_term_r;
   reg  [TERM_W-1:0]   line_decrement_term_nxt;
   reg  [TERM_W-1:0]   line_increment_term_nxt;
   reg  [WIDTH_W-1:0]  width_nxt;
   reg  [HEIGHT_W-1:0] height_nxt;
   reg                 err_load;
   reg                 line_go;
   reg                 trap_go;
   reg  [31:0]         rdata_nxt;
   wire                acc_wr;
   wire                acc_rd;
   wire                inhibit_bit;
   wire                trap_bit;
   // decoded pieces of the write word
   wire                keep_trail;
   wire                start_accept;
   wire [TERM_W-1:0]   term_field;
   wire [WIDTH_W-1:0]  len_width_field;
   wire [HEIGHT_W-1:0] len_height_field;

   // io-space cycles never reach these registers
   assign acc_wr      = reg_wr_in & mem_space_in;
   assign acc_rd      = reg_rd_in & mem_space_in;
   assign inhibit_bit = reg_wdata_in[`BIT_LINE_START_INHIBIT];
   assign trap_bit    = reg_wdata_in[`BIT_TRAP_START];

   assign term_field       = reg_wdata_in[TERM_W-1:0];
   // length and trap bit are the low width bits; any length write lands there
   assign len_width_field  = reg_wdata_in[WIDTH_W-1:0];
   assign len_height_field = reg_wdata_in[`RSVD_LSB+1:`TRAIL_LSB];
   // the 01 code starts a trapezoid but leaves the trailing position alone
   assign keep_trail       = trap_bit & ~inhibit_bit;
   // a start during a draw is dropped; the walker is not restartable mid-span
   assign start_accept     = (line_go | trap_go) & ~busy_out;

   // terms read back sign-extended, so software sees the signed value it wrote
   function [31:0] sext_term;
      input [TERM_W-1:0] t;
      begin
         sext_term = {{(32-TERM_W){t[TERM_W-1]}}, t};
      end
   endfunction

   // bit 31 only gates a plain line; a trapezoid request wins over it
   function [1:0] start_decode;
      input inhibit;
      input trap;
      begin
         case ({inhibit, trap})
            2'b00:   start_decode = START_LINE;
            2'b01:   start_decode = START_TRAP;
            2'b10:   start_decode = START_NONE;
            2'b11:   start_decode = START_TRAP;
            default: start_decode = START_NONE;
         endcase
      end
   endfunction

   always @* begin
      line_decrement_term_nxt = line_decrement_term_r;
      line_increment_term_nxt = line_increment_term_r;
      width_nxt               = destination_width_out;
      height_nxt              = destination_height_out;
      err_load                = 1'b0;
      line_go                 = 1'b0;
      trap_go                 = 1'b0;
      if (acc_wr) begin
         case (reg_idx_in)
            `IDX_LINE_DECREMENT_TERM: begin
               line_decrement_term_nxt = reg_wdata_in[TERM_W-1:0];
            end
            `IDX_LINE_INCREMENT_TERM: begin
               line_increment_term_nxt = reg_wdata_in[TERM_W-1:0];
            end
            `IDX_LINE_ERROR_TERM: begin
               // a load while walking is ignored inside the walker
               err_load = 1'b1;
            end
            `IDX_LINE_LENGTH_START: begin
               width_nxt = len_width_field;
               if (!keep_trail) begin
                  height_nxt = len_height_field;
               end
               {line_go, trap_go} = start_decode(inhibit_bit, trap_bit);
            end
            default: begin
               err_load = 1'b0;
            end
         endcase
      end
   end

   always @* begin
      // unmapped indices read zero but still answer, so the host never waits
      rdata_nxt = `RST_DATA;
      case (reg_idx_in)
         `IDX_LINE_DECREMENT_TERM: rdata_nxt = sext_term(line_decrement_term_r);
         `IDX_LINE_INCREMENT_TERM: rdata_nxt = sext_term(line_increment_term_r);
         `IDX_LINE_ERROR_TERM:     rdata_nxt = sext_term(line_error_term_out);
         // bit 31 always reads zero, the inhibit is never held
         `IDX_LINE_LENGTH_START:   rdata_nxt = {1'b0, destination_height_out, destination_width_out};
         default:                  rdata_nxt = `RST_DATA;
      endcase
   end

   // programmable terms and the aliased destination fields
   always @(posedge sys_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         line_decrement_term_r  <= `RST_TERM;
         line_increment_term_r  <= `RST_TERM;
         destination_width_out  <= `RST_WIDTH;
         destination_height_out <= `RST_HEIGHT;
      end else begin
         line_decrement_term_r  <= line_decrement_term_nxt;
         line_increment_term_r  <= line_increment_term_nxt;
         destination_width_out  <= width_nxt;
         destination_height_out <= height_nxt;
      end
   end

   // read answer and start pulses
   always @(posedge sys_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         reg_rdata_out  <= `RST_DATA;
         reg_rvalid_out <= 1'b0;
         line_start_out <= 1'b0;
         trap_start_out <= 1'b0;
         trap_mode_out  <= 1'b0;
      end else begin
         reg_rvalid_out <= acc_rd;
         if (acc_rd) begin
            reg_rdata_out <= rdata_nxt;
         end
         line_start_out <= line_go & start_accept;
         trap_start_out <= trap_go & start_accept;
         if (start_accept) begin
            trap_mode_out <= trap_go;
         end
      end
   end

   // the leading edge of a trapezoid shares the line walker
   // only bits 14:0 count; bit 15 is the trapezoid request
   bres_edge_walker #(
      .TERM_W (TERM_W),
      .LEN_W  (LEN_W)
   ) bres_edge_walker_inst (
      .sys_clk_in     (sys_clk_in),
      .arst_n_in      (arst_n_in),
      .err_load_in    (err_load),
      .err_value_in   (term_field),
      .start_in       (start_accept),
      .length_in      (reg_wdata_in[LEN_W-1:0]),
      .last_pixel_in  (draw_last_pixel_in),
      .inc_term_in    (line_increment_term_r),
      .dec_term_in    (line_decrement_term_r),
      .err_out        (line_error_term_out),
      .remaining_out  (remaining_out),
      .busy_out       (busy_out),
      .step_axial_out (step_axial_out),
      .step_diag_out  (step_diag_out),
      .done_out       (done_out)
   );

endmodule // bresenham_line_trap_setup

/* File: bresenham_line_trap_setup_bench.sv */
// self-checking bench for the line and trapezoid setup block
`timescale 1ns/1ps
module bresenham_line_trap_setup_bench;
   reg         sys_clk_in = 1'b0;
   reg         arst_n_in = 1'b0;
   reg         mem_space_in = 1'b1;
   reg         reg_wr_in = 1'b0;
   reg         reg_rd_in = 1'b0;
   reg         draw_last_pixel_in = 1'b0;
   reg  [7:0]  reg_idx_in = 8'h00;
   reg  [31:0] reg_wdata_in = 32'h00000000;
   wire [31:0] reg_rdata_out;
   wire [15:0] destination_width_out;
   wire [14:0] destination_height_out, remaining_out;
   wire [17:0] line_error_term_out;
   wire        reg_rvalid_out, line_start_out, trap_start_out, trap_mode_out;
   wire        busy_out, step_axial_out, step_diag_out, done_out;
   integer     n_mismatch = 0;
   integer     n_compared = 0;
   integer     n_cyc = 0;
   integer     it, i, dx, dy, mx, mn, cnt, e, inc, dec;
   reg  [31:0] seed = 32'h3BC61619;
   reg  [31:0] d;
   reg  [14:0] hgt = 15'h0000;
   reg         c31, c15;

   bresenham_line_trap_setup bresenham_line_trap_setup_inst (
      .sys_clk_in(sys_clk_in), .arst_n_in(arst_n_in), .mem_space_in(mem_space_in), .reg_wr_in(reg_wr_in),
      .reg_rd_in(reg_rd_in), .reg_idx_in(reg_idx_in), .reg_wdata_in(reg_wdata_in),
      .draw_last_pixel_in(draw_last_pixel_in), .reg_rdata_out(reg_rdata_out), .reg_rvalid_out(reg_rvalid_out),
      .destination_width_out(destination_width_out), .destination_height_out(destination_height_out),
      .line_start_out(line_start_out), .trap_start_out(trap_start_out), .trap_mode_out(trap_mode_out),
      .busy_out(busy_out), .line_error_term_out(line_error_term_out), .remaining_out(remaining_out),
      .step_axial_out(step_axial_out), .step_diag_out(step_diag_out), .done_out(done_out));

   always #2 sys_clk_in = ~sys_clk_in;

   function integer rnd(input integer m);
      begin
         seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
         rnd = seed % m;
      end
   endfunction

   task end_of_test;
      begin
         $display("mismatches %0d compared %0d", n_mismatch, n_compared);
         if (n_mismatch == 0 && n_compared > 0)
            $display("TEST PASSED");
         else
            $display("TEST FAILED");
         $finish;
      end
   endtask

   // a hung walk must still reach the verdict
   always @(posedge sys_clk_in) begin
      n_cyc = n_cyc + 1;
      if (n_cyc == 5000) begin
         n_mismatch = n_mismatch + 1;
         end_of_test;
      end
   end

   task chk(input [31:0] got, input [31:0] exp);
      begin
         n_compared = n_compared + 1;
         if (got !== exp) begin
            n_mismatch = n_mismatch + 1;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
         end
      end
   endtask

   task wr(input [7:0] idx, input [31:0] dat, input ms);
      begin
         @(negedge sys_clk_in);
         reg_wr_in = 1'b1;
         reg_idx_in = idx;
         reg_wdata_in = dat;
         mem_space_in = ms;
         @(negedge sys_clk_in);
         reg_wr_in = 1'b0;
         mem_space_in = 1'b1;
      end
   endtask

   // io-space reads must stay unanswered
   task rd(input [7:0] idx, input [31:0] exp, input ms);
      begin
         @(negedge sys_clk_in);
         reg_rd_in = 1'b1;
         reg_idx_in = idx;
         mem_space_in = ms;
         @(negedge sys_clk_in);
         reg_rd_in = 1'b0;
         mem_space_in = 1'b1;
         chk(reg_rvalid_out, ms);
         if (ms)
            chk(reg_rdata_out, exp);
      end
   endtask

   initial begin
      repeat (8) @(posedge sys_clk_in);
      @(negedge sys_clk_in);
      arst_n_in = 1'b1;
      rd(8'h48, 32'h0, 1'b1);
      rd(8'h20, 32'h0, 1'b1);
      wr(8'h4A, 32'h00000155, 1'b0);
      rd(8'h4A, 32'h0, 1'b0);
      rd(8'h4A, 32'h0, 1'b1);
      for (it = 0; it < 12; it = it + 1) begin
         dx = rnd(15) + 1;
         dy = rnd(16);
         mx = dx > dy ? dx : dy;
         mn = dx > dy ? dy : dx;
         inc = 2 * mn;
         dec = 2 * (mn - mx);
         e = 2 * mn - mx;
         c31 = it[1];
         c15 = it[0];
         draw_last_pixel_in = rnd(2);
         wr(8'h43, dec, 1'b1);
         wr(8'h49, e, 1'b1);
         wr(8'h4A, inc, 1'b1);
         rd(8'h43, dec, 1'b1);
         rd(8'h49, e, 1'b1);
         rd(8'h4A, inc, 1'b1);
         d = {c31, 15'h0000, c15, 15'h0000} | (rnd(32768) << 16) | (mx + 1);
         if (c31 || !c15)
            hgt = d[30:16];
         cnt = draw_last_pixel_in ? mx + 1 : mx;
         wr(8'h48, d, 1'b1);
         chk(line_start_out, !c31 && !c15);
         chk(trap_start_out, c15);
         chk(destination_width_out, d[15:0]);
         chk(destination_height_out, hgt);
         if (!c31 || c15) begin
            chk(remaining_out, cnt);
            chk(trap_mode_out, c15);
            for (i = cnt - 1; i >= 0; i = i - 1) begin
               chk(line_error_term_out, e[17:0]);
               @(negedge sys_clk_in);
               chk(step_axial_out, e < 0);
               chk(step_diag_out, e >= 0);
               e = e + (e < 0 ? inc : dec);
               chk(remaining_out, i);
               chk(done_out, i == 0);
            end
         end
         chk(busy_out, 0);
         rd(8'h48, {1'b0, hgt, d[15:0]}, 1'b1);
      end
      // a start while walking is dropped, then a reset cuts the walk
      wr(8'h48, 32'h00000008, 1'b1);
      wr(8'h48, 32'h00008004, 1'b1);
      chk(trap_start_out, 0);
      chk(trap_mode_out, 0);
      chk(busy_out, 1);
      chk(destination_width_out, 32'h00008004);
      arst_n_in = 1'b0;
      #1;
      chk(busy_out, 0);
      chk(destination_width_out, 0);
      @(negedge sys_clk_in);
      arst_n_in = 1'b1;
      rd(8'h48, 32'h0, 1'b1);
      end_of_test;
   end
endmodule // bresenham_line_trap_setup_bench

/* File: bresenham_line_trap_setup_checker.sv */
// port-level assertions for the line and trapezoid setup block
`timescale 1ns/1ps
module bresenham_line_trap_setup_checker (
   input wire logic        sys_clk_in,
   input wire logic        arst_n_in,
   input wire logic        mem_space_in,
   input wire logic        reg_wr_in,
   input wire logic        reg_rd_in,
   input wire logic [7:0]  reg_idx_in,
   input wire logic [31:0] reg_wdata_in,
   input wire logic        reg_rvalid_out,
   input wire logic [15:0] destination_width_out,
   input wire logic [14:0] destination_height_out,
   input wire logic        line_start_out,
   input wire logic        trap_start_out,
   input wire logic        busy_out,
   input wire logic [17:0] line_error_term_out,
   input wire logic [14:0] remaining_out,
   input wire logic        step_axial_out,
   input wire logic        step_diag_out,
   input wire logic        done_out
);
   default clocking @(posedge sys_clk_in); endclocking
   default disable iff (!arst_n_in);
   sequence s_len_wr;
      reg_wr_in && mem_space_in && reg_idx_in == 8'h48;
   endsequence
   sequence s_last_step;
      busy_out && remaining_out == 15'h0001;
   endsequence
   a_line_start: assert property (s_len_wr ##0 (!busy_out && !reg_wdata_in[31] && !reg_wdata_in[15])
      |=> line_start_out && !trap_start_out) else $error("line did not start");
   a_start_inhibit: assert property (s_len_wr ##0 (reg_wdata_in[31] && !reg_wdata_in[15])
      |=> !line_start_out && !trap_start_out) else $error("inhibited write started a draw");
   a_trap_start: assert property (s_len_wr ##0 (!busy_out && reg_wdata_in[15])
      |=> trap_start_out && !line_start_out) else $error("trapezoid did not start");
   a_width_alias: assert property (s_len_wr |=> destination_width_out == $past(reg_wdata_in[15:0]))
      else $error("width not loaded from length word");
   a_height_alias: assert property (s_len_wr ##0 (reg_wdata_in[31] || !reg_wdata_in[15])
      |=> destination_height_out == $past(reg_wdata_in[30:16])) else $error("height not loaded");
   a_height_keep: assert property (s_len_wr ##0 (!reg_wdata_in[31] && reg_wdata_in[15])
      |=> $stable(destination_height_out)) else $error("height changed on plain trapezoid start");
   a_io_ignored: assert property (reg_rd_in && !mem_space_in |=> !reg_rvalid_out)
      else $error("io space read answered");
   a_axial_step: assert property (busy_out && line_error_term_out[17] |=> step_axial_out && !step_diag_out)
      else $error("negative error without axial step");
   a_diag_step: assert property (busy_out && !line_error_term_out[17] |=> step_diag_out && !step_axial_out)
      else $error("non-negative error without diagonal step");
   a_count_down: assert property (busy_out |=> remaining_out + 15'h0001 == $past(remaining_out))
      else $error("pixel count did not step down");
   a_walk_end: assert property (s_last_step |=> done_out && !busy_out)
      else $error("walk did not end at zero");
   a_busy_drop: assert property (s_len_wr ##0 busy_out |=> !line_start_out && !trap_start_out)
      else $error("start accepted during a walk");
endmodule // bresenham_line_trap_setup_checker

bind bresenham_line_trap_setup bresenham_line_trap_setup_checker bresenham_line_trap_setup_checker_inst (
   .sys_clk_in(sys_clk_in), .arst_n_in(arst_n_in), .mem_space_in(mem_space_in), .reg_wr_in(reg_wr_in),
   .reg_rd_in(reg_rd_in), .reg_idx_in(reg_idx_in), .reg_wdata_in(reg_wdata_in), .reg_rvalid_out(reg_rvalid_out),
   .destination_width_out(destination_width_out), .destination_height_out(destination_height_out),
   .line_start_out(line_start_out), .trap_start_out(trap_start_out), .busy_out(busy_out),
   .line_error_term_out(line_error_term_out), .remaining_out(remaining_out),
   .step_axial_out(step_axial_out), .step_diag_out(step_diag_out), .done_out(done_out));
